//--- design/sesc_map.svh
// constants for the sector erase host controller
// assumes a 50 MHz clock and an asynchronous parallel flash bus
// How it works
// - sector erase is six writes: unlock pair, 80, unlock pair, 30 at sector.
// - each unlock pair is AA at 555 then 55 at 2AA.
// - host spaces extra sector writes under 50 us apart.
// - host loads extra sectors only inside the window; a suspend there closes it.
// - progress is polled at an address inside an erasing sector.
// - hardware reset aborts erase; host repeats the full sequence after.
// - resume is 30 at an address in the suspended sector.
`ifndef SESC_MAP_SVH
`define SESC_MAP_SVH
// software registers of the controller
`define SESC_CTRL_OFS 4'h0
`define SESC_SECT_OFS 4'h1
`define SESC_STAT_OFS 4'h2
`define SESC_ADDR_OFS 4'h3
`define SESC_DATA_OFS 4'h4
// control fields
`define SESC_CTRL_START 0
`define SESC_CTRL_ADD 1
`define SESC_CTRL_SUSP 2
`define SESC_CTRL_RESUME 3
`define SESC_CTRL_READ 4
`define SESC_CTRL_RESET 5
// flash command values
`define SESC_UNLOCK1_ADDR 23'h000555
`define SESC_UNLOCK2_ADDR 23'h0002AA
`define SESC_UNLOCK1_DATA 16'h00AA
`define SESC_UNLOCK2_DATA 16'h0055
`define SESC_SETUP_DATA 16'h0080
`define SESC_ERASE_DATA 16'h0030
`define SESC_SUSP_DATA 16'h00B0
// status bit positions
`define SESC_POLL_BIT 7
`define SESC_TOGGLE_BIT 6
`define SESC_WINDOW_BIT 3
`define SESC_SUSP_TOGGLE_BIT 2
// timing
`define SESC_CLK_MHZ 50
`define SESC_WINDOW_US 50
`define SESC_WINDOW_CYC (`SESC_WINDOW_US * `SESC_CLK_MHZ)
`define SESC_SUSP_US 20
`define SESC_SUSP_CYC (`SESC_SUSP_US * `SESC_CLK_MHZ)
`define SESC_STROBE_CYC 4
`define SESC_RST_CYC 25
`endif

//--- design/sesc_pkg.sv
// types for the sector erase host controller
// assumes the constants header is included by the controller
package sesc_pkg;
  typedef enum logic [3:0] {
    SESC_IDLE, SESC_WR_SETUP, SESC_WR_STROBE, SESC_WR_HOLD,
    SESC_RD_SETUP, SESC_RD_SAMPLE, SESC_RST_HOLD
  } sesc_bus_t;
endpackage

//--- design/sesc_host.sv
// host controller driving a parallel flash for sector erase and suspend
// assumes a flash on flash_* pins and software on the plain register port
//
// Decided for this implementation: the address map and the plain strobed port.
`timescale 1ns/1ps
`include "sesc_map.svh"
module sesc_host #(
  parameter int ADDR_W = 23,
  parameter int DATA_W = 16,
  parameter int WINDOW_CYC = `SESC_WINDOW_CYC
) (
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic [3:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  output logic [ADDR_W-1:0] flash_addr_o,
  output logic [DATA_W-1:0] flash_dq_o,
  output logic flash_dq_oe_o,
  input wire logic [DATA_W-1:0] flash_dq_i,
  output logic flash_we_n_o,
  output logic flash_oe_n_o,
  output logic flash_ce_n_o,
  output logic flash_reset_n_o
);
  // ==========================================================
  // state
  sesc_pkg::sesc_bus_t bus_reg;
  logic [2:0] seq_reg;        // index within the six write sequence
  logic [2:0] seq_len_reg;    // writes in the current command
  logic [ADDR_W-1:0] sect_reg;
  logic [7:0] cnt_reg;
  logic [15:0] win_reg;       // cycles since last erase write
  logic win_open_reg;
  logic suspended_reg;
  logic erasing_reg;
  logic abort_reg;
  logic [DATA_W-1:0] rd_data_reg;
  logic last_toggle_reg;
  logic have_toggle_reg;
  logic done_reg;
  logic busy;
  logic [ADDR_W-1:0] wa;
  logic [DATA_W-1:0] wd;

  assign busy = (bus_reg != sesc_pkg::SESC_IDLE);

  // ==========================================================
  // address and data of the current write step
  always_comb begin
    wa = sect_reg;
    wd = `SESC_ERASE_DATA;
    if (seq_len_reg == 3'd6) begin
      case (seq_reg)
        3'd0, 3'd3: begin
          wa = `SESC_UNLOCK1_ADDR;
          wd = `SESC_UNLOCK1_DATA;
        end
        3'd1, 3'd4: begin
          wa = `SESC_UNLOCK2_ADDR;
          wd = `SESC_UNLOCK2_DATA;
        end
        3'd2: begin
          wa = `SESC_UNLOCK1_ADDR;
          wd = `SESC_SETUP_DATA;
        end
        default: begin
          wa = sect_reg;
          wd = `SESC_ERASE_DATA;
        end
      endcase
    end else if (seq_reg == 3'd7 && !suspended_reg) begin
      wd = `SESC_SUSP_DATA;
    end
  end

  // ==========================================================
  // data pin synchroniser, the flash drives the bus with no clock of ours
  logic [DATA_W-1:0] dq_s1_reg;
  logic [DATA_W-1:0] dq_s2_reg;
  logic [DATA_W-1:0] dq_s3_reg;
  logic [DATA_W-1:0] dq_sync_reg;  // word taken once stages two and three agree

  // three stages; a settled word is ready one cycle before the read sample
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      dq_s1_reg <= '0;
      dq_s2_reg <= '0;
      dq_s3_reg <= '0;
      dq_sync_reg <= '0;
    end else begin
      dq_s1_reg <= flash_dq_i;
      dq_s2_reg <= dq_s1_reg;
      dq_s3_reg <= dq_s2_reg;
      if (dq_s2_reg == dq_s3_reg) begin
        dq_sync_reg <= dq_s3_reg;
      end
    end
  end

  // ==========================================================
  // bus sequencer: commands, strobes and reads
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      bus_reg <= sesc_pkg::SESC_IDLE;
      seq_reg <= 3'd0;
      seq_len_reg <= 3'd0;
      sect_reg <= '0;
      cnt_reg <= 8'h00;
      flash_addr_o <= '0;
      flash_dq_o <= '0;
      flash_dq_oe_o <= 1'b0;
      flash_we_n_o <= 1'b1;
      flash_oe_n_o <= 1'b1;
      flash_ce_n_o <= 1'b1;
      flash_reset_n_o <= 1'b1;
      rd_data_reg <= '0;
    end else begin
      case (bus_reg)
        sesc_pkg::SESC_IDLE: begin
          if (reg_wr_i && reg_addr_i == `SESC_SECT_OFS) begin
            sect_reg <= reg_wdata_i[ADDR_W-1:0];
          end else if (reg_wr_i && reg_addr_i == `SESC_CTRL_OFS) begin
            seq_reg <= 3'd0;
            if (reg_wdata_i[`SESC_CTRL_START]) begin
              seq_len_reg <= 3'd6;
              bus_reg <= sesc_pkg::SESC_WR_SETUP;
            end else if (reg_wdata_i[`SESC_CTRL_ADD] && win_open_reg) begin
              seq_len_reg <= 3'd1;
              seq_reg <= 3'd5;
              bus_reg <= sesc_pkg::SESC_WR_SETUP;
            end else if ((reg_wdata_i[`SESC_CTRL_SUSP] && erasing_reg && !suspended_reg)
                         || (reg_wdata_i[`SESC_CTRL_RESUME] && suspended_reg)) begin
              seq_len_reg <= 3'd1;
              seq_reg <= 3'd7;
              bus_reg <= sesc_pkg::SESC_WR_SETUP;
            end else if (reg_wdata_i[`SESC_CTRL_READ]) begin
              bus_reg <= sesc_pkg::SESC_RD_SETUP;
            end else if (reg_wdata_i[`SESC_CTRL_RESET]) begin
              flash_reset_n_o <= 1'b0;
              bus_reg <= sesc_pkg::SESC_RST_HOLD;
            end
          end
          cnt_reg <= 8'h00;
        end
        sesc_pkg::SESC_WR_SETUP: begin
          flash_addr_o <= wa;
          flash_dq_o <= wd;
          flash_dq_oe_o <= 1'b1;
          flash_ce_n_o <= 1'b0;
          flash_we_n_o <= 1'b0;
          cnt_reg <= 8'h00;
          bus_reg <= sesc_pkg::SESC_WR_STROBE;
        end
        sesc_pkg::SESC_WR_STROBE: begin
          cnt_reg <= cnt_reg + 8'h01;
          if (cnt_reg == 8'(`SESC_STROBE_CYC)) begin
            flash_we_n_o <= 1'b1; // rising strobe latches data
            bus_reg <= sesc_pkg::SESC_WR_HOLD;
          end
        end
        sesc_pkg::SESC_WR_HOLD: begin
          flash_ce_n_o <= 1'b1;
          flash_dq_oe_o <= 1'b0;
          if (seq_len_reg == 3'd6 && seq_reg != 3'd5) begin
            seq_reg <= seq_reg + 3'd1;
            bus_reg <= sesc_pkg::SESC_WR_SETUP;
          end else begin
            bus_reg <= sesc_pkg::SESC_IDLE;
          end
        end
        sesc_pkg::SESC_RD_SETUP: begin
          flash_addr_o <= sect_reg;
          flash_ce_n_o <= 1'b0;
          flash_oe_n_o <= 1'b0;
          cnt_reg <= 8'h00;
          bus_reg <= sesc_pkg::SESC_RD_SAMPLE;
        end
        sesc_pkg::SESC_RD_SAMPLE: begin
          cnt_reg <= cnt_reg + 8'h01;
          if (cnt_reg == 8'(`SESC_STROBE_CYC)) begin
            rd_data_reg <= dq_sync_reg;
            flash_ce_n_o <= 1'b1;
            flash_oe_n_o <= 1'b1;
            bus_reg <= sesc_pkg::SESC_IDLE;
          end
        end
        sesc_pkg::SESC_RST_HOLD: begin
          cnt_reg <= cnt_reg + 8'h01;
          if (cnt_reg == 8'(`SESC_RST_CYC)) begin
            flash_reset_n_o <= 1'b1;
            bus_reg <= sesc_pkg::SESC_IDLE;
          end
        end
        default: bus_reg <= sesc_pkg::SESC_IDLE;
      endcase
    end
  end

  // ==========================================================
  // window timer and erase progress tracking
  logic wr_done;
  logic rd_done;
  assign wr_done = (bus_reg == sesc_pkg::SESC_WR_STROBE) && cnt_reg == 8'(`SESC_STROBE_CYC);
  assign rd_done = (bus_reg == sesc_pkg::SESC_RD_SAMPLE) && cnt_reg == 8'(`SESC_STROBE_CYC);

  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      win_reg <= 16'h0000;
      win_open_reg <= 1'b0;
      erasing_reg <= 1'b0;
      suspended_reg <= 1'b0;
      abort_reg <= 1'b0;
    end else begin
      if (wr_done && seq_reg == 3'd5) begin
        win_reg <= 16'h0000; // window restarts at strobe rise
        win_open_reg <= 1'b1;
        erasing_reg <= 1'b1;
        abort_reg <= 1'b0;
      end else if (wr_done && seq_reg == 3'd7) begin
        win_open_reg <= 1'b0;
        suspended_reg <= !suspended_reg;
      end else if (win_open_reg) begin
        win_reg <= win_reg + 16'h0001;
        if (win_reg == 16'(WINDOW_CYC - 1)) begin
          win_open_reg <= 1'b0; // no further additions
        end
      end
      if (bus_reg == sesc_pkg::SESC_RST_HOLD) begin
        erasing_reg <= 1'b0;
        suspended_reg <= 1'b0;
        win_open_reg <= 1'b0;
        if (erasing_reg) begin
          abort_reg <= 1'b1; // mark survives the whole reset pulse
        end
      end else if (rd_done && erasing_reg && !suspended_reg
                   && dq_sync_reg[`SESC_POLL_BIT] && !win_open_reg) begin
        erasing_reg <= 1'b0;
      end
    end
  end

  // ==========================================================
  // toggle tracking across successive polls
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      last_toggle_reg <= 1'b0;
      have_toggle_reg <= 1'b0;
      done_reg <= 1'b0;
    end else if (rd_done) begin
      last_toggle_reg <= dq_sync_reg[`SESC_TOGGLE_BIT];
      have_toggle_reg <= 1'b1;
      // no toggle between reads means not erasing
      done_reg <= have_toggle_reg && (last_toggle_reg == dq_sync_reg[`SESC_TOGGLE_BIT]);
    end
  end

  // ==========================================================
  // register read port, data one cycle after strobe
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      reg_rdata_o <= 32'h00000000;
    end else if (reg_rd_i) begin
      if (reg_addr_i == `SESC_STAT_OFS) begin
        reg_rdata_o <= {24'h000000, abort_reg, done_reg, have_toggle_reg,
          rd_data_reg[`SESC_WINDOW_BIT], suspended_reg, erasing_reg, win_open_reg, busy};
      end else if (reg_addr_i == `SESC_DATA_OFS) begin
        reg_rdata_o <= 32'(rd_data_reg);
      end else if (reg_addr_i == `SESC_SECT_OFS) begin
        reg_rdata_o <= 32'(sect_reg);
      end else begin
        reg_rdata_o <= 32'h00000000;
      end
    end else begin
      reg_rdata_o <= 32'h00000000;
    end
  end

  // ==========================================================
  // checks
  chk_seq_setup: assert property (@(posedge clock_i) disable iff (reset_i)
    (bus_reg == sesc_pkg::SESC_WR_SETUP && seq_len_reg == 3'd6 && seq_reg == 3'd2)
    |=> (flash_dq_o == `SESC_SETUP_DATA)) else $error("setup data wrong");
  chk_unlock_addr: assert property (@(posedge clock_i) disable iff (reset_i)
    (bus_reg == sesc_pkg::SESC_WR_SETUP && seq_len_reg == 3'd6 && seq_reg == 3'd1)
    |=> (flash_addr_o == `SESC_UNLOCK2_ADDR && flash_dq_o == `SESC_UNLOCK2_DATA))
    else $error("unlock write wrong");
  chk_window_start: assert property (@(posedge clock_i) disable iff (reset_i)
    (wr_done && seq_reg == 3'd5) |=> (win_open_reg && win_reg == 16'h0000))
    else $error("window not opened");
  chk_window_len: assert property (@(posedge clock_i) disable iff (reset_i)
    (win_open_reg && win_reg == 16'(WINDOW_CYC - 1) && !wr_done) |=> !win_open_reg)
    else $error("window length wrong");
  chk_suspend_now: assert property (@(posedge clock_i) disable iff (reset_i)
    (wr_done && seq_reg == 3'd7) |=> !win_open_reg) else $error("window not closed");
  chk_reset_abort: assert property (@(posedge clock_i) disable iff (reset_i)
    (bus_reg == sesc_pkg::SESC_RST_HOLD) |=> !erasing_reg) else $error("reset kept erase");
  chk_strobe_pulse: assert property (@(posedge clock_i) disable iff (reset_i)
    $fell(flash_we_n_o) |-> !flash_we_n_o [*5] ##1 flash_we_n_o) else $error("strobe width");
  chk_resume_addr: assert property (@(posedge clock_i) disable iff (reset_i)
    (bus_reg == sesc_pkg::SESC_WR_SETUP && seq_reg == 3'd7 && suspended_reg)
    |=> (flash_addr_o == sect_reg && flash_dq_o == `SESC_ERASE_DATA))
    else $error("resume wrong");
  chk_add_sector: assert property (@(posedge clock_i) disable iff (reset_i)
    (bus_reg == sesc_pkg::SESC_WR_SETUP && seq_len_reg == 3'd1 && seq_reg == 3'd5)
    |=> (flash_addr_o == sect_reg && flash_dq_o == `SESC_ERASE_DATA)) else $error("add sector write wrong");
  chk_suspend_data: assert property (@(posedge clock_i) disable iff (reset_i)
    (bus_reg == sesc_pkg::SESC_WR_SETUP && seq_reg == 3'd7 && !suspended_reg)
    |=> (flash_addr_o == sect_reg && flash_dq_o == `SESC_SUSP_DATA)) else $error("suspend write wrong");
  chk_abort_mark: assert property (@(posedge clock_i) disable iff (reset_i)
    (bus_reg == sesc_pkg::SESC_RST_HOLD && erasing_reg) |=> abort_reg) else $error("abort not marked");
endmodule

//--- verif/sesc_flash_model.sv
// behavioural flash device for the sector erase host bench
// assumes async strobes from the host; no clock, times in ns
`timescale 1ns/1ps
module sesc_flash_model #(
  parameter real WIN_NS = 1000.0,
  parameter real ERASE_NS = 20000.0
) (
  input wire logic [22:0] addr_i,
  input wire logic [15:0] dq_i,
  output logic [15:0] dq_o,
  input wire logic we_n_i,
  input wire logic oe_n_i,
  input wire logic ce_n_i,
  input wire logic reset_n_i
);
  // 0 read, 1..5 unlock steps, 6 window, 7 erasing, 8 suspended
  logic [3:0] st = 4'h0;
  logic [255:0] set = '0;
  logic [255:0] blank = '0;  // sectors whose erase ran to the end
  logic [22:0] log_a [0:63];
  logic [7:0] log_d [0:63];
  int log_n = 0;
  realtime t0 = 0.0;
  realtime done = 0.0;
  logic tgl = 1'b0;
  logic tgl2 = 1'b0;
  logic [15:0] last = 16'h0000;
  logic [10:0] sq_a [0:4] = '{11'h555, 11'h2AA, 11'h555, 11'h555, 11'h2AA};
  logic [7:0] sq_d [0:4] = '{8'hAA, 8'h55, 8'h80, 8'hAA, 8'h55};
  wire hit = st >= 4'h6 && set[addr_i[22:15]];
  // command decode at write strobe rise
  always @(posedge we_n_i) begin
    if (!ce_n_i && reset_n_i) begin
      log_a[log_n] = addr_i;
      log_d[log_n] = dq_i[7:0];
      log_n++;
      if (st == 4'h6 && dq_i[7:0] == 8'h30) begin
        set[addr_i[22:15]] = 1'b1;
        t0 = $realtime;
      end else if (st >= 4'h6 && st <= 4'h7 && dq_i[7:0] == 8'hB0) st = 4'h8;
      else if (st == 4'h6) begin
        st = 4'h0;
        set = '0;
      end else if (st == 4'h8 && dq_i[7:0] == 8'h30 && hit) st = 4'h7;
      else if (st >= 4'h7) st = st; // other writes leave the state as it is
      else if (st == 4'h5 && dq_i[7:0] == 8'h30) begin
        set[addr_i[22:15]] = 1'b1;
        t0 = $realtime;
        st = 4'h6;
      end else if (st < 4'h5 && addr_i[10:0] == sq_a[st] && dq_i[7:0] == sq_d[st]) st = st + 4'h1;
      else st = 4'h0;
    end
  end
  // window expiry, unaided erase, hardware reset
  always #50 begin
    if (!reset_n_i) begin
      st = 4'h0;
      set = '0;
    end else if (st == 4'h6 && $realtime - t0 >= WIN_NS) begin
      st = 4'h7;
      done = 0.0;
    end else if (st == 4'h7) begin
      done = done + 50.0;
      if (done >= ERASE_NS) begin
        st = 4'h0;
        blank = blank | set;
        set = '0;
      end
    end
  end
  // toggles advance on each read: tgl in window or erase, tgl2 only inside a chosen sector
  always @(negedge oe_n_i) begin
    if (st == 4'h7 || st == 4'h6) tgl = ~tgl;
    if (hit) tgl2 = ~tgl2;
  end
  // read path; a released bus shows the inverse of the last value
  always @(posedge oe_n_i) last = dq_o;
  always @* begin
    if (oe_n_i || ce_n_i) dq_o = ~last;
    else if (hit) dq_o = {8'h00, st == 4'h8, tgl, 1'b0, 1'b0, st != 4'h6, tgl2, 2'b00};
    else if (blank[addr_i[22:15]]) dq_o = 16'hFFFF; // erased words read all ones
    else dq_o = addr_i[15:0] ^ 16'h5A5A;
  end
endmodule

//--- verif/sesc_host_test.sv
// bench for the sector erase host controller
// assumes the design files and the flash model are compiled first
`timescale 1ns/1ps
module sesc_host_test;
  logic clock_i = 1'b0;
  logic reset_i = 1'b1;
  logic [3:0] ra = 4'h0;
  logic [31:0] wd = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdat, v, w;
  logic [22:0] fa;
  logic [15:0] fdo, fdi, mdq;
  logic foe, we_n, oe_n, ce_n, rst_n;
  int error_cnt = 0;
  int n_checks = 0;
  logic [22:0] sa = 23'h0A8000;
  logic [22:0] sb = 23'h038000;
  // shared data line and clock
  assign fdi = foe ? fdo : mdq;
  always #10 clock_i = ~clock_i;
  sesc_host #(.WINDOW_CYC(50)) u_sesc_host (.clock_i(clock_i), .reset_i(reset_i), .reg_addr_i(ra),
    .reg_wdata_i(wd), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdat), .flash_addr_o(fa),
    .flash_dq_o(fdo), .flash_dq_oe_o(foe), .flash_dq_i(fdi), .flash_we_n_o(we_n),
    .flash_oe_n_o(oe_n), .flash_ce_n_o(ce_n), .flash_reset_n_o(rst_n));
  sesc_flash_model u_sesc_flash_model (.addr_i(fa), .dq_i(fdi), .dq_o(mdq), .we_n_i(we_n),
    .oe_n_i(oe_n), .ce_n_i(ce_n), .reset_n_i(rst_n));
  // ====================
  // helpers
  function automatic logic [31:0] lg(input int k);
    return {1'b0, u_sesc_flash_model.log_a[k], u_sesc_flash_model.log_d[k]};
  endfunction
  function automatic logic [31:0] st();
    return {28'h0, u_sesc_flash_model.st};
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wreg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock_i);
    ra <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clock_i);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [3:0] a, output logic [31:0] d);
    @(posedge clock_i);
    ra <= a;
    rd <= 1'b1;
    @(posedge clock_i);
    rd <= 1'b0;
    #1 d = rdat;
  endtask
  task automatic idle();
    v = 32'h1;
    for (int i = 0; i < 300 && v[0] !== 1'b0; i++) rreg(4'h2, v);
    chk({31'h0, v[0]}, 32'h0);
  endtask
  task automatic poll(output logic [31:0] d);
    wreg(4'h0, 32'h10);
    idle();
    rreg(4'h4, d);
  endtask
  // ====================
  // scenarios
  task automatic t_start();
    int b;
    logic [31:0] e [0:5];
    e = '{32'h555AA, 32'h2AA55, 32'h55580, 32'h555AA, 32'h2AA55, {1'b0, sa, 8'h30}};
    b = u_sesc_flash_model.log_n;
    wreg(4'h1, {9'h0, sa});
    wreg(4'h0, 32'h1);
    idle();
    for (int i = 0; i < 6; i++) chk(lg(b + i), e[i]);
    chk(st(), 32'h6);
  endtask
  task automatic t_add();
    wreg(4'h1, {9'h0, sb});
    wreg(4'h0, 32'h2);
    idle();
    chk(lg(u_sesc_flash_model.log_n - 1), {1'b0, sb, 8'h30});
    chk({24'h0, u_sesc_flash_model.st, 3'h0, u_sesc_flash_model.set[7]}, 32'h61);
  endtask
  task automatic t_poll();
    #2000;
    wreg(4'h3, {9'h0, sa});
    wreg(4'h1, {9'h0, sa});
    poll(v);
    chk({30'h0, v[7], v[3]}, 32'h1);
    chk(st(), 32'h7);
  endtask
  task automatic t_susp();
    wreg(4'h0, 32'h4);
    idle();
    chk(lg(u_sesc_flash_model.log_n - 1) & 32'hFF, 32'hB0);
    chk(st(), 32'h8);
    poll(w);
    poll(v);
    chk({30'h0, v[7], v[6]}, {30'h0, 1'b1, w[6]});
  endtask
  task automatic t_resume();
    wreg(4'h0, 32'h8);
    idle();
    w = lg(u_sesc_flash_model.log_n - 1);
    chk({16'h0, w[30:23], w[7:0]}, 32'h1530);
    chk(st(), 32'h7);
  endtask
  task automatic t_reset();
    wreg(4'h0, 32'h20);
    idle();
    chk({24'h0, u_sesc_flash_model.st, 3'h0, rst_n}, 32'h1);
    chk({27'h0, v[7], v[3:0]}, 32'h10);
  endtask
  task automatic t_wsusp();
    wreg(4'h0, 32'h4);
    idle();
    chk(st(), 32'h8);
  endtask
  task automatic t_done();
    v = 32'h4;
    for (int i = 0; i < 200 && v[2] !== 1'b0; i++) begin
      poll(w);
      rreg(4'h2, v);
    end
    chk({28'h0, v[3:0]}, 32'h0);
    chk(w, 32'h0000FFFF);
    chk(st(), 32'h0);
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // ====================
  // main sequence and watchdog
  initial begin
    repeat (16) @(posedge clock_i);
    reset_i <= 1'b0;
    t_start();
    t_add();
    t_poll();
    t_susp();
    t_resume();
    t_reset();
    t_start();
    t_wsusp();
    t_resume();
    t_done();
    conclude();
  end
  initial begin
    #400000;
    error_cnt++;
    conclude();
  end
endmodule
